// ### core/irtc_consts.svh
// Offsets, field positions, reset values and fixed patterns of the IR timer block.
// Assumes APB byte address = register index times four.
`ifndef IRTC_CONSTS_SVH
`define IRTC_CONSTS_SVH

// ==================================================
// Register indices
`define IRTC_IDX_NCTL      4'h0
`define IRTC_IDX_CCTL      4'h1
`define IRTC_IDX_WCTL      4'h2
`define IRTC_IDX_SHARED    4'h3
`define IRTC_IDX_NCONST_LO 4'h4
`define IRTC_IDX_NCONST_HI 4'h5
`define IRTC_IDX_WCONST_LO 4'h6
`define IRTC_IDX_WHOLD_HI  4'h7
`define IRTC_IDX_WCAP_LO   4'h8
`define IRTC_IDX_WCAP_HI   4'h9
`define IRTC_IDX_NCAP_LO   4'hA
`define IRTC_IDX_NCAP_HI   4'hB
`define IRTC_IDX_LAST      4'hB

// ==================================================
// Field positions
`define IRTC_EN_BIT        7
`define IRTC_TOUT_BIT      5
`define IRTC_DEMOD_BIT     0
`define IRTC_ONCE_BIT      6
`define IRTC_IRQEN_BIT     2
`define IRTC_ALT_BIT       7
`define IRTC_ESEL_HI       5
`define IRTC_ESEL_LO       4
`define IRTC_RISE_BIT      1
`define IRTC_FALL_BIT      0
`define IRTC_SH_WEN_BIT    7
`define IRTC_SH_NEN_BIT    6
`define IRTC_SH_SYNC_BIT   5

// ==================================================
// Reset values and patterns
`define IRTC_CTL_RST       8'h00
`define IRTC_CONST_RST     8'hFF
`define IRTC_CAP_RST       8'h00
`define IRTC_SH_RESERVED   5'h1F
`define IRTC_NARROW_ONES   8'hFF
`define IRTC_WIDE_ONES     16'hFFFF

`endif

// ### core/irtc_pkg.sv
// Types shared by the IR timer block.
// Assumes nothing of its surroundings.
package irtc_pkg;
  typedef logic [7:0]  irtc_addr_t;
  typedef logic [31:0] irtc_word_t;
  typedef logic [7:0]  irtc_byte_t;
  typedef logic [3:0]  irtc_idx_t;
  typedef enum logic [1:0] {
    DS_WAIT  = 2'b00,
    DS_COUNT = 2'b01,
    DS_HOLD  = 2'b10
  } irtc_dstate_t;
endpackage : irtc_pkg

// ### core/irtc_reg_if.sv
// Register access carrier between the APB slave and the timer core.
// Assumes one write strobe per APB access phase.
`timescale 1ns/10ps
interface irtc_reg_if;
  import irtc_pkg::*;
  logic       wr;
  irtc_idx_t  idx;
  irtc_byte_t wdata;
  irtc_byte_t rdata;
  modport bus  (output wr, output idx, output wdata, input rdata);
  modport core (input wr, input idx, input wdata, output rdata);
endinterface : irtc_reg_if

// ### core/irtc_apb_slave.sv
// APB slave front end: decode, write strobe, registered read data.
// Assumes an APB master that holds its request until pready.
`timescale 1ns/10ps
`include "irtc_consts.svh"
module irtc_apb_slave (
  input  logic              clk_i,
  input  logic              rst_i,
  input  logic              psel_i,
  input  logic              penable_i,
  input  logic              pwrite_i,
  input  irtc_pkg::irtc_addr_t paddr_i,
  input  irtc_pkg::irtc_word_t pwdata_i,
  output irtc_pkg::irtc_word_t prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  irtc_reg_if.bus           rb
);
  import irtc_pkg::*;

  logic mapped;

  // ==================================================
  // Decode
  assign mapped    = (paddr_i[1:0] == 2'h0) && (paddr_i[7:6] == 2'h0) && (paddr_i[5:2] <= `IRTC_IDX_LAST);
  assign rb.idx    = paddr_i[5:2];
  assign rb.wdata  = pwdata_i[7:0];
  assign rb.wr     = psel_i & penable_i & pwrite_i & mapped;
  // No wait states: read data is caught in the setup cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // ==================================================
  // Read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prdata_o <= 32'h00000000;
    else if (psel_i && !penable_i && !pwrite_i)
      prdata_o <= mapped ? {24'h000000, rb.rdata} : 32'h00000000;
  end
endmodule : irtc_apb_slave

// ### core/irtc_edge_detect.sv
// Edge detector on the demodulation input.
// Assumes the input is already synchronous to the clock.
`timescale 1ns/10ps
module irtc_edge_detect (
  input  logic       clk_i,
  input  logic       rst_i,
  input  logic       din_i,
  input  logic [1:0] sel_i,
  output logic       rise_o,
  output logic       fall_o,
  output logic       hit_o
);
  logic prev;
  logic primed;

  // ==================================================
  // History
  // Primed flag keeps a high input at release from faking a rise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev   <= 1'b0;
      primed <= 1'b0;
    end
    else
    begin
      prev   <= din_i;
      primed <= 1'b1;
    end
  end

  assign rise_o = primed & din_i & ~prev;
  assign fall_o = primed & ~din_i & prev;
  assign hit_o  = (sel_i[0] & rise_o) | (sel_i[1] & fall_o);
endmodule : irtc_edge_detect

// ### core/irtc_top.sv
// IR capture and demodulation timers: one narrow and one wide down counter.
// Assumes an APB master on the register port and a clean synchronous pulse input.
//
// How it works
// - Narrow high capture holds input-low count; low capture holds input-high count.
// - Wide capture split: high byte in one register, low byte in another.
// - Software writes to the four capture registers change nothing.
// - Narrow counter wrapping zero to all ones never flags a timeout.
// - Software stop and status clear act one timer clock later.
// - Narrow demodulation: first selected edge after enable starts the down count.
// - Narrow demodulation: later selected edges store the inverted count.
// - Wide count of zero wraps to all ones and continues, no timeout.
// - Wide demodulation: first edge captures, reloads and starts counting.
// - With wide control bit six clear, later edges store the inverted count.
// - Each wide capture sets an edge status bit; interrupt only when enabled.
// - After each wide capture the counter reloads all ones and restarts.
// - Alternating mode hands the run enable back and forth between timers.
// - Alternating mode sets each timeout bit at every terminal count.
// - Shared control reserved bits ignore writes and read as ones.
// - Sync mode bit follows shared control writes to bit five; reset clears it.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "irtc_consts.svh"
module irtc_top (
  input  logic                 REF_CLK_I,
  input  logic                 RST_I,
  input  logic                 PSEL_I,
  input  logic                 PENABLE_I,
  input  logic                 PWRITE_I,
  input  irtc_pkg::irtc_addr_t PADDR_I,
  input  irtc_pkg::irtc_word_t PWDATA_I,
  output irtc_pkg::irtc_word_t PRDATA_O,
  output logic                 PREADY_O,
  output logic                 PSLVERR_O,
  input  logic                 DEMOD_IN_I,
  output logic                 WIDE_IRQ_O
);
  import irtc_pkg::*;

  irtc_reg_if rb ();

  logic         n_en;
  logic         w_en;
  logic         n_demod;
  logic         w_demod;
  logic         w_once;
  logic         w_irq_en;
  logic         alt_mode;
  logic [1:0]   edge_sel;
  logic         sync_mode;
  logic         nto;
  logic         wto;
  logic         st_rise;
  logic         st_fall;
  irtc_byte_t   nconst_lo;
  irtc_byte_t   nconst_hi;
  irtc_byte_t   wconst_lo;
  irtc_byte_t   whold_hi;
  irtc_byte_t   ncap_hi;
  irtc_byte_t   ncap_lo;
  irtc_byte_t   wcap_hi;
  irtc_byte_t   wcap_lo;
  logic [7:0]   ncnt;
  logic [15:0]  wcnt;
  irtc_dstate_t nstate;
  irtc_dstate_t wstate;
  logic         pend_n_v;
  logic         pend_n_d;
  logic         pend_w_v;
  logic         pend_w_d;
  logic [3:0]   pend_clr;
  logic         edge_rise;
  logic         edge_fall;
  logic         edge_hit;
  logic         n_term;
  logic         w_term;
  logic         n_cap;
  logic         w_cap;

  // ==================================================
  // Bus and input front ends
  irtc_apb_slave u_apb (
    .clk_i     (REF_CLK_I),
    .rst_i     (RST_I),
    .psel_i    (PSEL_I),
    .penable_i (PENABLE_I),
    .pwrite_i  (PWRITE_I),
    .paddr_i   (PADDR_I),
    .pwdata_i  (PWDATA_I),
    .prdata_o  (PRDATA_O),
    .pready_o  (PREADY_O),
    .pslverr_o (PSLVERR_O),
    .rb        (rb.bus)
  );

  irtc_edge_detect u_edge (
    .clk_i  (REF_CLK_I),
    .rst_i  (RST_I),
    .din_i  (DEMOD_IN_I),
    .sel_i  (edge_sel),
    .rise_o (edge_rise),
    .fall_o (edge_fall),
    .hit_o  (edge_hit)
  );

  // ==================================================
  // Event terms
  // Terminal count is the one to zero step; zero itself wraps
  assign n_term = n_en & ~n_demod & (ncnt == 8'h01);
  assign w_term = w_en & ~w_demod & (wcnt == 16'h0001);
  assign n_cap  = n_en & n_demod & (nstate == DS_COUNT) & edge_hit;
  assign w_cap  = w_en & w_demod & edge_hit & ((wstate == DS_WAIT) | ((wstate == DS_COUNT) & ~w_once));

  // ==================================================
  // Configuration registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      n_demod   <= 1'b0;
      w_demod   <= 1'b0;
      w_once    <= 1'b0;
      w_irq_en  <= 1'b0;
      alt_mode  <= 1'b0;
      edge_sel  <= 2'b00;
      sync_mode <= 1'b0;
      nconst_lo <= `IRTC_CONST_RST;
      nconst_hi <= `IRTC_CONST_RST;
      wconst_lo <= `IRTC_CONST_RST;
      whold_hi  <= `IRTC_CONST_RST;
    end
    else if (rb.wr)
    begin
      case (rb.idx)
        `IRTC_IDX_NCTL:
          n_demod <= rb.wdata[`IRTC_DEMOD_BIT];
        `IRTC_IDX_CCTL:
        begin
          alt_mode <= rb.wdata[`IRTC_ALT_BIT];
          edge_sel <= rb.wdata[`IRTC_ESEL_HI:`IRTC_ESEL_LO];
        end
        `IRTC_IDX_WCTL:
        begin
          w_once   <= rb.wdata[`IRTC_ONCE_BIT];
          w_irq_en <= rb.wdata[`IRTC_IRQEN_BIT];
          w_demod  <= rb.wdata[`IRTC_DEMOD_BIT];
        end
        `IRTC_IDX_SHARED:
          sync_mode <= rb.wdata[`IRTC_SH_SYNC_BIT];
        `IRTC_IDX_NCONST_LO:
          nconst_lo <= rb.wdata;
        `IRTC_IDX_NCONST_HI:
          nconst_hi <= rb.wdata;
        `IRTC_IDX_WCONST_LO:
          wconst_lo <= rb.wdata;
        `IRTC_IDX_WHOLD_HI:
          whold_hi <= rb.wdata;
        // Capture registers take no write
        default:
          sync_mode <= sync_mode;
      endcase
    end
  end

  // ==================================================
  // Deferred software commands
  // Stop and clear wait one timer clock, as the counter would see them
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      pend_n_v <= 1'b0;
      pend_n_d <= 1'b0;
      pend_w_v <= 1'b0;
      pend_w_d <= 1'b0;
      pend_clr <= 4'h0;
    end
    else
    begin
      pend_n_v <= rb.wr & ((rb.idx == `IRTC_IDX_NCTL) | (rb.idx == `IRTC_IDX_SHARED));
      pend_n_d <= (rb.idx == `IRTC_IDX_SHARED) ? rb.wdata[`IRTC_SH_NEN_BIT] : rb.wdata[`IRTC_EN_BIT];
      pend_w_v <= rb.wr & ((rb.idx == `IRTC_IDX_WCTL) | (rb.idx == `IRTC_IDX_SHARED));
      pend_w_d <= (rb.idx == `IRTC_IDX_SHARED) ? rb.wdata[`IRTC_SH_WEN_BIT] : rb.wdata[`IRTC_EN_BIT];
      pend_clr[0] <= rb.wr & (rb.idx == `IRTC_IDX_NCTL) & rb.wdata[`IRTC_TOUT_BIT];
      pend_clr[1] <= rb.wr & (rb.idx == `IRTC_IDX_WCTL) & rb.wdata[`IRTC_TOUT_BIT];
      pend_clr[2] <= rb.wr & (rb.idx == `IRTC_IDX_CCTL) & rb.wdata[`IRTC_RISE_BIT];
      pend_clr[3] <= rb.wr & (rb.idx == `IRTC_IDX_CCTL) & rb.wdata[`IRTC_FALL_BIT];
    end
  end

  // ==================================================
  // Run enables
  // Explicit software command beats the hardware hand-over
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      n_en <= 1'b0;
      w_en <= 1'b0;
    end
    else
    begin
      if (pend_n_v)
        n_en <= pend_n_d;
      else if (alt_mode && n_term)
        n_en <= 1'b0;
      else if (alt_mode && w_term)
        n_en <= 1'b1;
      if (pend_w_v)
        w_en <= pend_w_d;
      else if (alt_mode && w_term)
        w_en <= 1'b0;
      else if (alt_mode && n_term)
        w_en <= 1'b1;
    end
  end

  // ==================================================
  // Status flags, set wins over clear
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      nto     <= 1'b0;
      wto     <= 1'b0;
      st_rise <= 1'b0;
      st_fall <= 1'b0;
    end
    else
    begin
      nto     <= (nto & ~pend_clr[0]) | n_term;
      wto     <= (wto & ~pend_clr[1]) | w_term;
      st_rise <= (st_rise & ~pend_clr[2]) | (w_cap & edge_rise);
      st_fall <= (st_fall & ~pend_clr[3]) | (w_cap & edge_fall);
    end
  end

  // ==================================================
  // Narrow timer
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      ncnt   <= `IRTC_CONST_RST;
      nstate <= DS_WAIT;
    end
    else if (!n_en)
    begin
      ncnt   <= nconst_lo;
      nstate <= DS_WAIT;
    end
    else if (n_demod)
    begin
      case (nstate)
        DS_WAIT:
          if (edge_hit)
          begin
            ncnt   <= nconst_lo;
            nstate <= DS_COUNT;
          end
        DS_COUNT:
          // Free wrap through zero, no timeout while demodulating
          ncnt <= edge_hit ? nconst_lo : ncnt - 8'h01;
        default:
          nstate <= DS_WAIT;
      endcase
    end
    else
      ncnt <= n_term ? nconst_lo : ncnt - 8'h01;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      ncap_hi <= `IRTC_CAP_RST;
      ncap_lo <= `IRTC_CAP_RST;
    end
    else if (n_cap)
    begin
      if (edge_rise)
        ncap_hi <= ~ncnt;
      if (edge_fall)
        ncap_lo <= ~ncnt;
    end
  end

  // ==================================================
  // Wide timer
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      wcnt   <= `IRTC_WIDE_ONES;
      wstate <= DS_WAIT;
    end
    else if (!w_en)
    begin
      wcnt   <= {whold_hi, wconst_lo};
      wstate <= DS_WAIT;
    end
    else if (w_demod)
    begin
      case (wstate)
        DS_WAIT:
          if (edge_hit)
          begin
            wcnt   <= `IRTC_WIDE_ONES;
            wstate <= w_once ? DS_HOLD : DS_COUNT;
          end
          else
            wcnt <= wcnt;
        DS_COUNT:
          wcnt <= w_cap ? `IRTC_WIDE_ONES : wcnt - 16'h0001;
        DS_HOLD:
          wcnt <= wcnt - 16'h0001;
        default:
          wstate <= DS_WAIT;
      endcase
    end
    else
      // Zero steps to all ones like any other count
      wcnt <= w_term ? {whold_hi, wconst_lo} : wcnt - 16'h0001;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      wcap_hi <= `IRTC_CAP_RST;
      wcap_lo <= `IRTC_CAP_RST;
    end
    else if (w_cap)
    begin
      wcap_hi <= ~wcnt[15:8];
      wcap_lo <= ~wcnt[7:0];
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      WIDE_IRQ_O <= 1'b0;
    else
      WIDE_IRQ_O <= w_cap & w_irq_en;
  end

  // ==================================================
  // Read mux
  always_comb
  begin
    case (rb.idx)
      `IRTC_IDX_NCTL:      rb.rdata = {n_en, 1'b0, nto, 4'h0, n_demod};
      `IRTC_IDX_CCTL:      rb.rdata = {alt_mode, 1'b0, edge_sel, 2'b00, st_rise, st_fall};
      `IRTC_IDX_WCTL:      rb.rdata = {w_en, w_once, wto, 2'b00, w_irq_en, 1'b0, w_demod};
      `IRTC_IDX_SHARED:    rb.rdata = {w_en, n_en, sync_mode, `IRTC_SH_RESERVED};
      `IRTC_IDX_NCONST_LO: rb.rdata = nconst_lo;
      `IRTC_IDX_NCONST_HI: rb.rdata = nconst_hi;
      `IRTC_IDX_WCONST_LO: rb.rdata = wconst_lo;
      `IRTC_IDX_WHOLD_HI:  rb.rdata = whold_hi;
      `IRTC_IDX_WCAP_LO:   rb.rdata = wcap_lo;
      `IRTC_IDX_WCAP_HI:   rb.rdata = wcap_hi;
      `IRTC_IDX_NCAP_LO:   rb.rdata = ncap_lo;
      `IRTC_IDX_NCAP_HI:   rb.rdata = ncap_hi;
      default:             rb.rdata = 8'h00;
    endcase
  end

  // ==================================================
  // Assertions
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  cap_write_ignored_a: assert property (
    (rb.wr && rb.idx == `IRTC_IDX_NCAP_HI && !n_cap) |=> $stable(ncap_hi))
    else $error("narrow high capture changed by a write");

  narrow_no_wrap_a: assert property (
    (n_en && ncnt == 8'h00) |=> !$rose(nto) || $past(n_term))
    else $error("narrow wrap raised a timeout");

  stop_delay_a: assert property (
    (rb.wr && rb.idx == `IRTC_IDX_NCTL && !rb.wdata[`IRTC_EN_BIT] && n_en && !alt_mode) |=> n_en ##1 !n_en)
    else $error("narrow stop not one clock late");

  narrow_capture_a: assert property (
    (n_cap && edge_rise) |=> (ncap_hi == ~$past(ncnt)) && $stable(ncap_lo))
    else $error("narrow rising capture wrong");

  falling_low_a: assert property (
    (n_cap && edge_fall) |=> (ncap_lo == ~$past(ncnt)) && $stable(ncap_hi))
    else $error("narrow falling capture wrong");

  wide_first_a: assert property (
    (w_en && w_demod && wstate == DS_WAIT && edge_hit && !pend_w_v) |=> wcnt == `IRTC_WIDE_ONES && wstate != DS_WAIT)
    else $error("wide first edge did not start count");

  wide_irq_a: assert property (
    w_cap |=> (st_rise || st_fall) && (WIDE_IRQ_O == $past(w_irq_en)))
    else $error("wide capture status or interrupt wrong");

  wide_reload_a: assert property (
    (w_cap && !pend_w_v) |=> wcnt == `IRTC_WIDE_ONES ##1 wcnt == 16'hFFFE || !w_en || w_cap)
    else $error("wide counter not reloaded");

  zero_wrap_a: assert property (
    (w_en && !w_demod && wcnt == 16'h0000 && !pend_w_v) |=> wcnt == 16'hFFFF && !$rose(wto))
    else $error("wide zero did not wrap quietly");

  alt_handover_a: assert property (
    (alt_mode && n_term && !pend_n_v && !pend_w_v) |=> !n_en && w_en)
    else $error("alternating hand-over failed");

  timeout_set_a: assert property (
    (n_term || w_term) |=> (nto || !$past(n_term)) && (wto || !$past(w_term)))
    else $error("timeout flag not set at terminal count");

  reserved_ones_a: assert property (
    (rb.idx == `IRTC_IDX_SHARED) |-> rb.rdata[4:0] == 5'h1F)
    else $error("shared reserved bits not ones");
endmodule : irtc_top

// ### verif/irtc_pulse_src.sv
// Pulse source on the demodulation input: equal high and low widths.
// Assumes the bench sets the width before run goes high.
`timescale 1ns/10ps
module irtc_pulse_src (
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic [31:0] width_i,
  output logic      pulse_o
);
  int cnt;
  initial
  begin
    pulse_o = 1'b0;
    cnt = 0;
  end
  // ==========================================
  // Toggle every width cycles; idle low when stopped
  always @(posedge clk_i)
  begin
    if (!run_i)
    begin
      pulse_o <= 1'b0;
      cnt <= 1;
    end
    else if (cnt >= width_i)
    begin
      pulse_o <= ~pulse_o;
      cnt <= 1;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : irtc_pulse_src

// ### verif/testbench.sv
// Self-checking bench: APB master, pulse source, register and capture checks.
// Assumes the zero-wait-state slave and one-clock delayed enables of the core.
`timescale 1ns/10ps
module testbench;
  import irtc_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, run = 1'b0;
  logic       pready, pslverr, din, irq, err;
  irtc_addr_t paddr = 8'h00;
  irtc_word_t pwdata = 32'h0, prdata, rd;
  int         n_mismatch = 0, cmp_count = 0, cyc = 0, n_irq = 0, w = 8;
  logic [1:0] seen;
  logic       both;

  always #10 clk = ~clk;

  irtc_top dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .DEMOD_IN_I(din), .WIDE_IRQ_O(irq));
  irtc_pulse_src src (.clk_i(clk), .run_i(run), .width_i(w), .pulse_o(din));

  // ==========================================
  // Timeout and interrupt pulse count
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (irq === 1'b1)
      n_irq <= n_irq + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input irtc_word_t e, input irtc_word_t g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // Request held until pready is sampled high
  task automatic apb(input logic wr, input irtc_addr_t a, input irtc_byte_t d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  function automatic irtc_word_t exp_cap(input int width);
    return width - 1;
  endfunction : exp_cap

  initial
  begin
    void'($urandom(32'h9CD3B670));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 4; i < 12; i++)
    begin
      apb(1'b0, i * 4, 8'h00);
      chk("reset value", (i < 8) ? 32'hFF : 32'h00, rd);
      apb(1'b1, i * 4, $urandom_range(255));
      if (i >= 8)
      begin
        apb(1'b0, i * 4, 8'h00);
        chk("capture write", 32'h00, rd);
      end
    end
    apb(1'b0, 8'h0C, 8'h00);
    chk("shared reset", 32'h1F, rd);
    apb(1'b1, 8'h0C, 8'h20);
    apb(1'b0, 8'h0C, 8'h00);
    chk("shared sync", 32'h3F, rd);
    apb(1'b0, 8'h30, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test registers done");
    // Narrow demodulation, both edges; equal widths make either level reading agree
    w = 4 + $urandom_range(40);
    apb(1'b1, 8'h10, 8'hFF);
    apb(1'b1, 8'h14, 8'hFF);
    apb(1'b1, 8'h04, 8'h30);
    apb(1'b1, 8'h00, 8'h81);
    run <= 1'b1;
    repeat (6 * w) @(posedge clk);
    apb(1'b1, 8'h00, 8'h01);
    repeat (3) @(posedge clk);
    run <= 1'b0;
    apb(1'b0, 8'h28, 8'h00);
    chk("narrow low cap", exp_cap(w), rd);
    apb(1'b0, 8'h2C, 8'h00);
    chk("narrow high cap", exp_cap(w), rd);
    $display("test narrow demod done");
    // Wide demodulation with and without interrupt enable
    apb(1'b1, 8'h18, 8'hFF);
    apb(1'b1, 8'h1C, 8'hFF);
    for (int ie = 0; ie < 2; ie++)
    begin
      w = 4 + $urandom_range(60);
      n_irq = 0;
      apb(1'b1, 8'h08, 8'h81 | (ie << 2));
      run <= 1'b1;
      repeat (6 * w) @(posedge clk);
      apb(1'b0, 8'h0C, 8'h00);
      chk("shared wide run", 32'h1, {31'h0, rd[7]});
      apb(1'b1, 8'h0C, 8'h00);
      repeat (3) @(posedge clk);
      run <= 1'b0;
      apb(1'b0, 8'h08, 8'h00);
      chk("wide stopped", 32'h0, {31'h0, rd[7]});
      apb(1'b0, 8'h20, 8'h00);
      chk("wide low cap", exp_cap(w) & 32'hFF, rd);
      apb(1'b0, 8'h24, 8'h00);
      chk("wide high cap", exp_cap(w) >> 8, rd);
      apb(1'b0, 8'h04, 8'h00);
      chk("edge status", 32'h3, {30'h0, rd[1:0]});
      chk("irq seen", ie, {31'h0, n_irq > 0});
      apb(1'b1, 8'h04, 8'h33);
      repeat (2) @(posedge clk);
      apb(1'b0, 8'h04, 8'h00);
      chk("status clear", 32'h0, {30'h0, rd[1:0]});
    end
    // Once bit set: only the first edge captures, and it sees the all-ones constant
    apb(1'b1, 8'h08, 8'hC1);
    run <= 1'b1;
    repeat (6 * w) @(posedge clk);
    apb(1'b1, 8'h08, 8'h00);
    run <= 1'b0;
    apb(1'b0, 8'h24, 8'h00);
    chk("once high cap", 32'h0, rd);
    apb(1'b0, 8'h20, 8'h00);
    chk("once low cap", 32'h0, rd);
    apb(1'b0, 8'h04, 8'h00);
    chk("once status", 32'h2, {30'h0, rd[1:0]});
    $display("test wide demod done");
    // Zero constant wraps without timeout; small constant reaches terminal count
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, k ? 8'h18 : 8'h10, 8'h00);
      apb(1'b1, 8'h1C, 8'h00);
      apb(1'b1, k ? 8'h08 : 8'h00, 8'h80);
      repeat (100) @(posedge clk);
      apb(1'b0, k ? 8'h08 : 8'h00, 8'h00);
      chk("wrap timeout", 32'h0, {31'h0, rd[5]});
      apb(1'b1, k ? 8'h08 : 8'h00, 8'h00);
      apb(1'b1, k ? 8'h18 : 8'h10, 8'h03);
      apb(1'b1, k ? 8'h08 : 8'h00, 8'h80);
      repeat (20) @(posedge clk);
      apb(1'b0, k ? 8'h08 : 8'h00, 8'h00);
      chk("terminal timeout", 32'h1, {31'h0, rd[5]});
    end
    $display("test timeout done");
    // Alternating mode: narrow runs three counts, wide five, never both at once
    apb(1'b1, 8'h0C, 8'h00);
    apb(1'b1, 8'h00, 8'h20);
    apb(1'b1, 8'h08, 8'h20);
    apb(1'b1, 8'h18, 8'h05);
    apb(1'b1, 8'h04, 8'hB0);
    apb(1'b1, 8'h00, 8'h80);
    seen = 2'b00;
    both = 1'b0;
    // Reads three clocks apart walk every phase of the eight clock cycle
    for (int j = 0; j < 8; j++)
    begin
      apb(1'b0, 8'h0C, 8'h00);
      seen = seen | rd[7:6];
      both = both | (rd[7] & rd[6]);
    end
    chk("alt both ran", 32'h3, {30'h0, seen});
    chk("alt overlap", 32'h0, {31'h0, both});
    apb(1'b0, 8'h00, 8'h00);
    chk("alt narrow timeout", 32'h1, {31'h0, rd[5]});
    apb(1'b0, 8'h08, 8'h00);
    chk("alt wide timeout", 32'h1, {31'h0, rd[5]});
    $display("test alternating done");
    summarize();
  end
endmodule : testbench
